// file: jlp_cfg.svh
// jlp_cfg.svh: offsets, field positions, reset values and fixed figures
// for the link parameter derivation block; definitions only.
`ifndef JLP_CFG_SVH
`define JLP_CFG_SVH

// register byte offsets
`define JLP_OFS_CTRL      8'h00
`define JLP_OFS_KLEN      8'h04
`define JLP_OFS_DEVID     8'h08
`define JLP_OFS_SHAPE     8'h0c
`define JLP_OFS_SAMPLE    8'h10
`define JLP_OFS_RATE      8'h14
`define JLP_OFS_CHKSUM    8'h18
`define JLP_OFS_STATUS    8'h1c

// control register fields
`define JLP_CTRL_EN_BIT   0
`define JLP_CTRL_SCR_BIT  1
`define JLP_CTRL_MODE_LSB 4
`define JLP_CTRL_MODE_MSB 7

// reset values
`define JLP_RST_MODE      4'h0
`define JLP_RST_KM1       8'h1f
`define JLP_RST_DID       8'h00

// fixed alignment field values and lane count
`define JLP_JESDV         8'h01
`define JLP_SUBCLASSV     8'h01
`define JLP_EXT_MB        9'h001
`define JLP_EMB_FRAMES    9'h100
`define JLP_LANES         8

`endif

// file: jlp_pkg.sv
// jlp_pkg.sv: types shared by the link parameter derivation block.
// assumes jlp_cfg.svh supplies the numeric constants.
package jlp_pkg;

   typedef struct packed {
      logic       enc64;
      logic [4:0] n;
      logic [4:0] np;
      logic [3:0] l;
      logic [3:0] m;
      logic [3:0] f;
      logic [2:0] s;
      logic [9:0] r_x32;
      logic [5:0] k_step;
   } jlp_mode_type;

endpackage

// file: jlp_param_derive.sv
// jlp_param_derive.sv: derives transport and link parameters of the
// serial transmitter from one mode selector plus a few user settings.
// assumes a single-cycle register port and one clock with clock enable.
//
// Implementation choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ns
`include "jlp_cfg.svh"

module jlp_param_derive
   import jlp_pkg::*;
(
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        ce_i,
   // register port
   input  wire logic [7:0]  addr_i,
   input  wire logic [31:0] wdata_i,
   input  wire logic        wr_i,
   input  wire logic        rd_i,
   output logic      [31:0] rdata_o,
   // link control
   output logic             link_rst_o,
   output logic [7:0]       lane_on_o,
   output logic             ilas_en_o,
   output logic             enc_64b66b_o,
   output logic [9:0]       pll_ratio_x32_o,
   // transport parameters
   output logic [8:0]       frames_per_mf_o,
   output logic [3:0]       lanes_o,
   output logic [3:0]       converters_o,
   output logic [3:0]       octets_o,
   output logic [2:0]       samples_o,
   output logic [4:0]       resolution_o,
   output logic [4:0]       sample_width_o,
   output logic             scrambler_o,
   output logic [7:0]       dev_id_o,
   // per lane alignment fields
   output logic [39:0]      lane_id_o,
   output logic [63:0]      lane_chksum_o
);

   logic               en_q;
   logic               scr_q;
   logic [3:0]         mode_sel_q;
   logic [7:0]         km1_q;
   logic [7:0]         did_q;
   logic               k_bad_q;
   jlp_mode_type       mode_d;
   logic [8:0]         k_d;
   logic [7:0]         chk_base_d;
   logic               k_bad_d;
   logic [31:0]        rdata_d;

   // mode table: every transport figure but the 8b/10b K follows from the selector
   function automatic jlp_mode_type mode_row(input logic [3:0] sel);
      jlp_mode_type t;
      t = '0;
      case (sel)
         4'h0: t = '{1'b0, 5'd12, 5'd12, 4'd8, 4'd8, 4'd8, 3'd5, 10'd256, 6'd4};
         4'h1: t = '{1'b0, 5'd12, 5'd12, 4'd6, 4'd4, 4'd2, 3'd2, 10'd320, 6'd16};
         4'h2: t = '{1'b0, 5'd8,  5'd8,  4'd4, 4'd4, 4'd1, 3'd1, 10'd320, 6'd32};
         4'h3: t = '{1'b0, 5'd10, 5'd10, 4'd4, 4'd4, 4'd5, 3'd4, 10'd400, 6'd32};
         4'h4: t = '{1'b1, 5'd12, 5'd12, 4'd3, 4'd4, 4'd2, 3'd1, 10'd528, 6'd0};
         4'h5: t = '{1'b1, 5'd8,  5'd8,  4'd2, 4'd4, 4'd2, 3'd1, 10'd528, 6'd0};
         4'h6: t = '{1'b1, 5'd12, 5'd12, 4'd6, 4'd4, 4'd2, 3'd2, 10'd264, 6'd0};
         4'h7: t = '{1'b1, 5'd8,  5'd8,  4'd4, 4'd4, 4'd1, 3'd1, 10'd264, 6'd0};
         4'h8: t = '{1'b1, 5'd12, 5'd12, 4'd4, 4'd4, 4'd3, 3'd2, 10'd396, 6'd0};
         4'h9: t = '{1'b0, 5'd8,  5'd8,  4'd8, 4'd4, 4'd1, 3'd2, 10'd160, 6'd32};
         4'ha: t = '{1'b0, 5'd10, 5'd10, 4'd8, 4'd8, 4'd5, 3'd4, 10'd200, 6'd32};
         4'hb: t = '{1'b0, 5'd12, 5'd12, 4'd8, 4'd8, 4'd8, 3'd5, 10'd128, 6'd4};
         4'hc: t = '{1'b0, 5'd8,  5'd8,  4'd8, 4'd2, 4'd1, 3'd4, 10'd80,  6'd32};
         4'hd: t = '{1'b0, 5'd10, 5'd10, 4'd8, 4'd8, 4'd5, 3'd4, 10'd100, 6'd32};
         4'he: t = '{1'b1, 5'd12, 5'd12, 4'd8, 4'd8, 4'd3, 3'd2, 10'd198, 6'd0};
         4'hf: t = '{1'b1, 5'd12, 5'd12, 4'd8, 4'd8, 4'd3, 3'd2, 10'd99,  6'd0};
         default: t = '0;
      endcase
      return t;
   endfunction

   // ---------------------------------------------------------------
   // register writes
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         en_q       <= 1'b0;
         scr_q      <= 1'b0;
         mode_sel_q <= `JLP_RST_MODE;
      end else if (ce_i && wr_i && addr_i == `JLP_OFS_CTRL) begin
         en_q       <= wdata_i[`JLP_CTRL_EN_BIT];
         scr_q      <= wdata_i[`JLP_CTRL_SCR_BIT];
         mode_sel_q <= wdata_i[`JLP_CTRL_MODE_MSB:`JLP_CTRL_MODE_LSB];
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         km1_q <= `JLP_RST_KM1;
         did_q <= `JLP_RST_DID;
      end else if (ce_i && wr_i) begin
         if (addr_i == `JLP_OFS_KLEN) begin
            km1_q <= wdata_i[7:0];
         end
         if (addr_i == `JLP_OFS_DEVID) begin
            did_q <= wdata_i[7:0];
         end
      end
   end

   // ---------------------------------------------------------------
   // derivation from the current settings
   // ---------------------------------------------------------------
   always_comb begin
      mode_d = mode_row(mode_sel_q);
      if (!mode_d.enc64) begin
         k_d = {1'b0, km1_q} + 9'd1;
      end else begin
         // extended multiblock count is fixed, user K ignored
         case (mode_d.f)
            4'd1:    k_d = `JLP_EMB_FRAMES * `JLP_EXT_MB;
            4'd2:    k_d = (`JLP_EMB_FRAMES * `JLP_EXT_MB) >> 1;
            4'd3:    k_d = 9'((`JLP_EMB_FRAMES * `JLP_EXT_MB) / 9'd3);
            default: k_d = `JLP_EMB_FRAMES * `JLP_EXT_MB;
         endcase
      end
      // 8b/10b K must be a whole multiple of the mode's step
      k_bad_d = !mode_d.enc64 && (k_d[5:0] & (mode_d.k_step - 6'd1)) != 6'd0;
   end

   // common part of the alignment checksum, lane id added per lane;
   // zero fields (adjust, bank, CS, CF, HD, reserved) add nothing
   always_comb begin
      chk_base_d = did_q
                 + {7'd0, scr_q}
                 + {4'd0, mode_d.l - 4'd1}
                 + {4'd0, mode_d.f - 4'd1}
                 + km1_q
                 + {4'd0, mode_d.m - 4'd1}
                 + {3'd0, mode_d.n - 5'd1}
                 + `JLP_SUBCLASSV
                 + {3'd0, mode_d.np - 5'd1}
                 + `JLP_JESDV
                 + {5'd0, mode_d.s - 3'd1};
   end

   // ---------------------------------------------------------------
   // link control: held in reset, lanes off while disabled
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         link_rst_o <= 1'b1;
         ilas_en_o  <= 1'b0;
      end else if (ce_i) begin
         link_rst_o <= !en_q;
         ilas_en_o  <= en_q && !enc_64b66b_o;
      end
   end

   // parameters are captured only while the link is disabled
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         enc_64b66b_o    <= 1'b0;
         pll_ratio_x32_o <= 10'd0;
         frames_per_mf_o <= 9'd0;
         lanes_o         <= 4'd0;
         converters_o    <= 4'd0;
         octets_o        <= 4'd0;
         samples_o       <= 3'd0;
         resolution_o    <= 5'd0;
         sample_width_o  <= 5'd0;
         scrambler_o     <= 1'b0;
         dev_id_o        <= 8'd0;
         k_bad_q         <= 1'b0;
      end else if (ce_i && !en_q) begin
         enc_64b66b_o    <= mode_d.enc64;
         pll_ratio_x32_o <= mode_d.r_x32;
         frames_per_mf_o <= k_d;
         lanes_o         <= mode_d.l;
         converters_o    <= mode_d.m;
         octets_o        <= mode_d.f;
         samples_o       <= mode_d.s;
         resolution_o    <= mode_d.n;
         sample_width_o  <= mode_d.np;
         scrambler_o     <= scr_q;
         dev_id_o        <= did_q;
         k_bad_q         <= k_bad_d;
      end
   end

   // per lane: identity from position, power only for lowest lanes
   genvar gi;
   generate
      for (gi = 0; gi < `JLP_LANES; gi = gi + 1) begin : g_lane
         always_ff @(posedge clk_i or posedge rst_i) begin
            if (rst_i) begin
               lane_on_o[gi]              <= 1'b0;
               lane_id_o[gi*5 +: 5]       <= 5'd0;
               lane_chksum_o[gi*8 +: 8]   <= 8'd0;
            end else if (ce_i) begin
               lane_on_o[gi] <= en_q && (4'(gi) < lanes_o);
               if (!en_q) begin
                  lane_id_o[gi*5 +: 5]     <= 5'(gi);
                  lane_chksum_o[gi*8 +: 8] <= chk_base_d + 8'(gi);
               end
            end
         end
      end
   endgenerate

   // ---------------------------------------------------------------
   // register reads: data in the cycle after the strobe, else zero
   // ---------------------------------------------------------------
   always_comb begin
      rdata_d = 32'h0;
      case (addr_i)
         `JLP_OFS_CTRL:   rdata_d = {24'h0, mode_sel_q, 2'b00, scr_q, en_q};
         `JLP_OFS_KLEN:   rdata_d = {24'h0, km1_q};
         `JLP_OFS_DEVID:  rdata_d = {24'h0, did_q};
         `JLP_OFS_SHAPE:  rdata_d = {13'h0, samples_o, octets_o, converters_o,
                                     lanes_o, 4'h0};
         `JLP_OFS_SAMPLE: rdata_d = {12'h0, frames_per_mf_o, enc_64b66b_o,
                                     sample_width_o, resolution_o};
         `JLP_OFS_RATE:   rdata_d = {22'h0, pll_ratio_x32_o};
         `JLP_OFS_CHKSUM: rdata_d = {24'h0, lane_chksum_o[7:0]};
         `JLP_OFS_STATUS: rdata_d = {28'h0, k_bad_q, ilas_en_o,
                                     |lane_on_o, link_rst_o};
         default:         rdata_d = 32'h0;
      endcase
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_o <= 32'h0;
      end else if (ce_i) begin
         rdata_o <= rd_i ? rdata_d : 32'h0;
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_link_reset_follow: assert property (
      ce_i |=> (link_rst_o == !$past(en_q)))
      else $error("link reset does not follow the enable");

   a_lanes_off_disabled: assert property (
      (ce_i && !en_q) |=> (lane_on_o == 8'h00))
      else $error("lane powered while link disabled");

   a_params_frozen: assert property (
      (ce_i && en_q) ##1 (ce_i && en_q) |=> $stable(frames_per_mf_o)
         && $stable(lanes_o) && $stable(lane_chksum_o))
      else $error("parameters changed while link enabled");

   a_k_from_user: assert property (
      (ce_i && !en_q && !mode_d.enc64)
         |=> (frames_per_mf_o == {1'b0, $past(km1_q)} + 9'd1))
      else $error("8b/10b K not taken from the user field");

   a_k_derived_64b: assert property (
      (ce_i && !en_q && mode_d.enc64 && mode_d.f == 4'd2)
         |=> (frames_per_mf_o == 9'd128))
      else $error("64b/66b K not derived from F");

   a_pll_ratio_mode: assert property (
      (ce_i && !en_q && mode_sel_q == 4'h4) |=> (pll_ratio_x32_o == 10'd528))
      else $error("serializer ratio wrong for the selected mode");

   a_no_ilas_64b: assert property (
      enc_64b66b_o |-> !ilas_en_o)
      else $error("alignment sequence enabled in 64b/66b mode");

   a_lane_id_step: assert property (
      (lane_id_o == {5'd7, 5'd6, 5'd5, 5'd4, 5'd3, 5'd2, 5'd1, 5'd0})
         || (lane_id_o == 40'h0))
      else $error("lane identifiers not positional");

   a_chksum_sum: assert property (
      !$past(ce_i && !en_q && !rst_i) || (lane_chksum_o[7:0] == 8'(dev_id_o
         + {7'd0, scrambler_o} + {4'd0, lanes_o - 4'd1}
         + {4'd0, octets_o - 4'd1} + $past(km1_q)
         + {4'd0, converters_o - 4'd1} + {3'd0, resolution_o - 5'd1}
         + 8'd1 + {3'd0, sample_width_o - 5'd1} + 8'd1
         + {5'd0, samples_o - 3'd1})))
      else $error("lane checksum is not the field sum");

   a_read_one_cycle: assert property (
      (ce_i && !rd_i) |=> (rdata_o == 32'h0))
      else $error("read data present without a read strobe");

   a_ilas_when_on: assert property (
      (ce_i && en_q && !enc_64b66b_o) |=> ilas_en_o)
      else $error("alignment sequence off on an enabled 8b/10b link");

   a_ilas_off_idle: assert property (
      (ce_i && !en_q) |=> !ilas_en_o)
      else $error("alignment sequence on while link disabled");

   a_k_full_64b: assert property (
      (ce_i && !en_q && mode_d.enc64 && mode_d.f == 4'd1) |=> (frames_per_mf_o == 9'd256))
      else $error("64b/66b K wrong for one octet per frame");

   a_k_third_64b: assert property (
      (ce_i && !en_q && mode_d.enc64 && mode_d.f == 4'd3) |=> (frames_per_mf_o == 9'd85))
      else $error("64b/66b K wrong for three octets per frame");

   a_user_fields: assert property (
      (ce_i && !en_q) |=> (dev_id_o == $past(did_q)) && (scrambler_o == $past(scr_q)))
      else $error("user link fields not applied while disabled");

   a_lanes_lowest: assert property (
      (ce_i && en_q) |=> (lane_on_o == 8'((9'h001 << $past(lanes_o)) - 9'h001)))
      else $error("powered lanes are not the lowest L lanes");

   a_chksum_per_lane: assert property (
      (lane_chksum_o == 64'h0)
         || ((lane_chksum_o[15:8] == lane_chksum_o[7:0] + 8'h01)
            && (lane_chksum_o[63:56] == lane_chksum_o[7:0] + 8'h07)))
      else $error("lane checksums do not step with the lane id");

   a_ce_freeze: assert property (
      !ce_i |=> $stable(rdata_o) && $stable(link_rst_o) && $stable(lane_on_o)
         && $stable(frames_per_mf_o))
      else $error("state moved while clock enable low");

endmodule

// file: jlp_rx_model.sv
// jlp_rx_model.sv: receiver-side model that checks the alignment fields of each active lane.
// assumes the field outputs of jlp_param_derive are wired straight in.
`timescale 1ns/1ns

module jlp_rx_model (
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // received alignment fields
   input  wire logic        ilas_en_i,
   input  wire logic [7:0]  lane_on_i,
   input  wire logic [8:0]  k_i,
   input  wire logic [3:0]  l_i,
   input  wire logic [3:0]  m_i,
   input  wire logic [3:0]  f_i,
   input  wire logic [2:0]  s_i,
   input  wire logic [4:0]  n_i,
   input  wire logic [4:0]  np_i,
   input  wire logic        scr_i,
   input  wire logic [7:0]  did_i,
   input  wire logic [39:0] lid_i,
   input  wire logic [63:0] sum_i,
   // faults seen
   output logic      [15:0] bad_o
);
   logic [7:0] base;
   // seven minus-one fields, two version fields of one, zero fields add nothing
   assign base = 8'(32'(did_i) + scr_i + l_i + f_i + k_i + m_i + n_i + np_i + s_i
                 - 32'd7 + 32'd2);
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         bad_o <= 16'h0000;
      end else begin
         for (int i = 0; i < 8; i++) begin
            if (ilas_en_i && lane_on_i[i]) begin
               if (lid_i[5*i +: 5] !== 5'(i) || sum_i[8*i +: 8] !== 8'(base + i)) begin
                  bad_o <= bad_o + 16'h0001;
               end
            end
         end
      end
   end
endmodule

// file: jlp_param_derive_bench.sv
// jlp_param_derive_bench.sv: self-checking bench for the link parameter block.
// assumes jlp_pkg, jlp_cfg.svh and jlp_rx_model are compiled first.
`timescale 1ns/1ns
`include "jlp_cfg.svh"

module jlp_param_derive_bench;
   import jlp_pkg::*;
   logic        clk_i, rst_i, ce_i, wr_i, rd_i, link_rst_o, ilas_en_o, enc_64b66b_o, scrambler_o;
   logic [7:0]  addr_i, lane_on_o, dev_id_o;
   logic [31:0] wdata_i, rdata_o, d;
   logic [9:0]  pll_ratio_x32_o;
   logic [8:0]  frames_per_mf_o, k;
   logic [3:0]  lanes_o, converters_o, octets_o;
   logic [2:0]  samples_o;
   logic [4:0]  resolution_o, sample_width_o;
   logic [39:0] lane_id_o;
   logic [63:0] lane_chksum_o;
   logic [15:0] bad;
   logic [7:0]  cs;
   logic [30:0] e;
   int          miscompares, num_checks, cycles;

   jlp_param_derive dut (.clk_i, .rst_i, .ce_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
      .link_rst_o, .lane_on_o, .ilas_en_o, .enc_64b66b_o, .pll_ratio_x32_o, .frames_per_mf_o,
      .lanes_o, .converters_o, .octets_o, .samples_o, .resolution_o, .sample_width_o,
      .scrambler_o, .dev_id_o, .lane_id_o, .lane_chksum_o);
   jlp_rx_model rx (.clk_i, .rst_i, .ilas_en_i(ilas_en_o), .lane_on_i(lane_on_o),
      .k_i(frames_per_mf_o),
      .l_i(lanes_o), .m_i(converters_o), .f_i(octets_o), .s_i(samples_o), .n_i(resolution_o),
      .np_i(sample_width_o), .scr_i(scrambler_o), .did_i(dev_id_o), .lid_i(lane_id_o),
      .sum_i(lane_chksum_o), .bad_o(bad));

   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end

   // enc, L, M, F, S, N, R times 32
   function automatic logic [30:0] row(input int m);
      case (m)
         0: row = {1'b0, 4'h8, 4'h8, 4'h8, 3'h5, 5'h0c, 10'h100};
         1: row = {1'b0, 4'h6, 4'h4, 4'h2, 3'h2, 5'h0c, 10'h140};
         2: row = {1'b0, 4'h4, 4'h4, 4'h1, 3'h1, 5'h08, 10'h140};
         3: row = {1'b0, 4'h4, 4'h4, 4'h5, 3'h4, 5'h0a, 10'h190};
         4: row = {1'b1, 4'h3, 4'h4, 4'h2, 3'h1, 5'h0c, 10'h210};
         5: row = {1'b1, 4'h2, 4'h4, 4'h2, 3'h1, 5'h08, 10'h210};
         6: row = {1'b1, 4'h6, 4'h4, 4'h2, 3'h2, 5'h0c, 10'h108};
         7: row = {1'b1, 4'h4, 4'h4, 4'h1, 3'h1, 5'h08, 10'h108};
         8: row = {1'b1, 4'h4, 4'h4, 4'h3, 3'h2, 5'h0c, 10'h18c};
         9: row = {1'b0, 4'h8, 4'h4, 4'h1, 3'h2, 5'h08, 10'h0a0};
         10: row = {1'b0, 4'h8, 4'h8, 4'h5, 3'h4, 5'h0a, 10'h0c8};
         11: row = {1'b0, 4'h8, 4'h8, 4'h8, 3'h5, 5'h0c, 10'h080};
         12: row = {1'b0, 4'h8, 4'h2, 4'h1, 3'h4, 5'h08, 10'h050};
         13: row = {1'b0, 4'h8, 4'h8, 4'h5, 3'h4, 5'h0a, 10'h064};
         14: row = {1'b1, 4'h8, 4'h8, 4'h3, 3'h2, 5'h0c, 10'h0c6};
         default: row = {1'b1, 4'h8, 4'h8, 4'h3, 3'h2, 5'h0c, 10'h063};
      endcase
   endfunction

   task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string msg);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: %s got %h exp %h", $time, msg, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk_i);
      wr_i    <= 1'b1;
      addr_i  <= a;
      wdata_i <= v;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge clk_i);
      rd_i   <= 1'b1;
      addr_i <= a;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 v = rdata_o;
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask

   task automatic finish_test;
      chk(bad, 64'h0, "receiver fields");
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         miscompares++;
         finish_test();
      end
   end

   initial begin
      rst_i = 1'b1; ce_i = 1'b1; wr_i = 1'b0; rd_i = 1'b0; addr_i = 8'h00; wdata_i = 32'h0;
      miscompares = 0; num_checks = 0;
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      tick(2);
      chk(link_rst_o, 1, "link held in reset");
      rd(`JLP_OFS_KLEN, d);
      chk(d, 32'h1f, "km1 reset value");
      $display("test reset done");
      for (int m = 0; m < 16; m++) begin
         e = row(m);
         k = e[30] ? 9'(256 / e[21:18]) : 9'h100;
         wr(`JLP_OFS_KLEN, 32'hff);
         wr(`JLP_OFS_DEVID, 32'(m * 16 + 3));
         wr(`JLP_OFS_CTRL, 32'(m * 16 + (m % 2) * 2));
         tick(1);
         chk({lanes_o, converters_o, octets_o, samples_o}, e[29:15], "shape");
         chk({resolution_o, sample_width_o}, {e[14:10], e[14:10]}, "widths");
         chk({enc_64b66b_o, pll_ratio_x32_o}, {e[30], e[9:0]}, "enc rate");
         chk(frames_per_mf_o, k, "frames per mf");
         chk({scrambler_o, dev_id_o}, {1'(m % 2), 8'(m * 16 + 3)}, "user fields");
         chk({link_rst_o, lane_on_o, ilas_en_o}, 10'h200, "disabled link");
         cs = 8'(m * 16 + 3 + m % 2 + e[29:26] + e[21:18] + 255 + e[25:22] + 2 * e[14:10]
            + e[17:15] - 4);
         for (int i = 0; i < e[29:26]; i++) begin
            chk(lane_id_o[5*i +: 5], 5'(i), "lane id");
            chk(lane_chksum_o[8*i +: 8], 8'(cs + i), "checksum");
         end
         rd(`JLP_OFS_RATE, d);
         chk(d, 32'(e[9:0]), "rate register");
         rd(`JLP_OFS_SAMPLE, d);
         chk(d, {12'h0, k, e[30], e[14:10], e[14:10]}, "sample register");
         rd(`JLP_OFS_SHAPE, d);
         chk(d, {13'h0, e[17:15], e[21:18], e[25:22], e[29:26], 4'h0}, "shape register");
         rd(`JLP_OFS_CHKSUM, d);
         chk(d, 32'(cs), "checksum register");
      end
      $display("test mode table done");
      wr(`JLP_OFS_CTRL, 32'h20);
      wr(`JLP_OFS_CTRL, 32'h21);
      tick(1);
      chk({link_rst_o, lane_on_o}, 9'h00f, "enabled lanes");
      tick(1);
      chk(ilas_en_o, 1, "alignment on in 8b10b");
      wr(`JLP_OFS_KLEN, 32'h3f);
      tick(3);
      chk(frames_per_mf_o, 9'h100, "frozen while enabled");
      wr(`JLP_OFS_CTRL, 32'h20);
      tick(2);
      chk({link_rst_o, lane_on_o, frames_per_mf_o}, 18'h20040, "applied after disable");
      wr(`JLP_OFS_CTRL, 32'h50);
      wr(`JLP_OFS_CTRL, 32'h51);
      tick(2);
      chk({ilas_en_o, lane_on_o, frames_per_mf_o}, 18'h00680, "64b66b link");
      $display("test enable done");
      wr(`JLP_OFS_KLEN, 32'h13);
      wr(`JLP_OFS_CTRL, 32'h10);
      tick(1);
      rd(`JLP_OFS_STATUS, d);
      chk(d, 32'h9, "k off step");
      @(posedge clk_i);
      ce_i <= 1'b0;
      wr(`JLP_OFS_DEVID, 32'h77);
      @(posedge clk_i);
      ce_i <= 1'b1;
      rd(`JLP_OFS_DEVID, d);
      chk(d, 32'hf3, "write with clock enable low");
      wr(8'h24, 32'hffffffff);
      rd(8'h20, d);
      chk(d, 32'h0, "unmapped read");
      rd(`JLP_OFS_KLEN, d);
      chk(d, 32'h13, "unmapped write ignored");
      rd(`JLP_OFS_CTRL, d);
      chk(d, 32'h10, "control readback");
      $display("test bus done");
      finish_test();
   end
endmodule
